// ===== rtl/fcp_host.sv
// host controller that sequences commands into the flash command interface
`timescale 1ns/1ps
module fcp_host
	import fcp_pkg::*;
(
	input  wire logic        CLK_I,
	input  wire logic        RSTN_I,
	input  wire logic        CE_I,
	input  wire fcp_req_t    REQ_I,
	input  wire logic        REQ_VALID_I,
	input  wire logic [7:0]  DQ_I,
	input  wire logic        SUPPLY_HIGH_I,
	output logic             REQ_READY_O,
	output logic             DONE_O,
	output logic             ERROR_O,
	output logic             REFUSED_O,
	output logic [7:0]       RDATA_O,
	output logic [7:0]       STATUS_O,
	output logic [19:0]      ADDR_O,
	output logic [7:0]       DQ_O,
	output logic             DQ_OE_N_O,
	output fcp_ctl_t         CTL_O
);
	fcp_state_t       state_ff, nxt_state;
	fcp_req_t         req_ff;
	logic [CNT_W-1:0] wait_ff;
	logic             pd_n_ff;
	logic             supply_low_seen_ff;
	logic             start_ff;
	logic             wr_ff;
	logic [7:0]       wdata_ff;
	logic [19:0]      baddr_ff;
	logic             cyc_busy, cyc_done;
	logic [7:0]       cyc_rdata;
	logic [19:0]      cyc_addr;
	logic [7:0]       cyc_dq;
	logic             cyc_dq_oe_n, cyc_cs_n, cyc_we_n, cyc_oe_n;

	function automatic logic stat_failed(input logic [7:0] s);
		stat_failed = s[BIT_ERASE_ERR] | s[BIT_WRITE_ERR] | s[BIT_SUPPLY_LOW];
	endfunction : stat_failed

	wire accept     = REQ_VALID_I && REQ_READY_O;
	wire is_alter   = (REQ_I.op == OP_WRITE) || (REQ_I.op == OP_ERASE);
	wire needs_bus  = (REQ_I.op != OP_SLEEP) && (REQ_I.op != OP_WAKE);
	// a set supply flag must be cleared first, so alter requests are refused [R1]
	// nothing reaches the pins while asleep; the device would ignore it anyway [R10]
	wire must_refuse = (is_alter && supply_low_seen_ff) || (needs_bus && !pd_n_ff);
	wire idle_go    = accept && !must_refuse;
	wire cyc_idle   = !cyc_busy && !start_ff;
	wire ready_now  = cyc_done && cyc_rdata[BIT_READY];

	fcp_bus_cycle u_cycle (
		.clk_i     (CLK_I),
		.rstn_i    (RSTN_I),
		.ce_i      (CE_I),
		.start_i   (start_ff),
		.wr_i      (wr_ff),
		.addr_i    (baddr_ff),
		.wdata_i   (wdata_ff),
		.dq_i      (DQ_I),
		.busy_o    (cyc_busy),
		.done_o    (cyc_done),
		.rdata_o   (cyc_rdata),
		.addr_o    (cyc_addr),
		.dq_o      (cyc_dq),
		.dq_oe_n_o (cyc_dq_oe_n),
		.cs_n_o    (cyc_cs_n),
		.we_n_o    (cyc_we_n),
		.oe_n_o    (cyc_oe_n)
	);

	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE:
				if (accept)
				begin
					if (must_refuse)
						nxt_state = ST_REFUSE;
					else if (REQ_I.op == OP_SLEEP)
						nxt_state = ST_SLEEP;
					else if (REQ_I.op == OP_WAKE)
						nxt_state = ST_WAKE;
					else if (REQ_I.op == OP_READ)
						nxt_state = ST_RDARR;
					else
						nxt_state = ST_CMD1;
				end
			ST_CMD1:
				if (cyc_done)
					nxt_state = (req_ff.op == OP_WRITE || req_ff.op == OP_ERASE) ? ST_CMD2 : ST_READ;
			ST_CMD2:
				if (cyc_done)
					nxt_state = ST_POLL;
			ST_POLL:
				if (ready_now)
					nxt_state = ST_RDARR;
			ST_RDARR:
				if (cyc_done)
					nxt_state = (req_ff.op == OP_READ) ? ST_READ : ST_DONE;
			ST_READ:
				if (cyc_done)
					nxt_state = (req_ff.op == OP_CLEAR) ? ST_DONE : ST_DONE;
			ST_SLEEP:
				nxt_state = ST_DONE;
			ST_WAKE:
				if (wait_ff == '0)
					nxt_state = ST_DONE;
			default:
				nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			state_ff <= ST_IDLE; req_ff <= '0; wait_ff <= '0; pd_n_ff <= 1'b0;
			supply_low_seen_ff <= 1'b0; start_ff <= 1'b0; wr_ff <= 1'b0; wdata_ff <= 8'h00;
			baddr_ff <= 20'h00000; REQ_READY_O <= 1'b0; DONE_O <= 1'b0; ERROR_O <= 1'b0;
			REFUSED_O <= 1'b0; RDATA_O <= 8'h00; STATUS_O <= {STAT_INIT_HI, 3'b000};
		end
		else if (CE_I)
		begin
			state_ff <= nxt_state;
			start_ff <= 1'b0;
			DONE_O <= 1'b0;
			REFUSED_O <= 1'b0;
			REQ_READY_O <= (nxt_state == ST_IDLE) && !accept;
			if (idle_go)
				req_ff <= REQ_I;
			// supply drop aborts the operation; latch it so the host refuses until cleared [R3] [R12]
			if (!SUPPLY_HIGH_I && state_ff == ST_POLL)
				supply_low_seen_ff <= 1'b1;
			case (state_ff)
				ST_IDLE:
					if (accept)
					begin
						REFUSED_O <= must_refuse;
						DONE_O <= must_refuse;
						if (REQ_I.op == OP_SLEEP)
						begin
							pd_n_ff <= 1'b0; // device clears status and enters array read [R4] [R6] [R10]
							supply_low_seen_ff <= 1'b0; // power-down clears the device supply flag too [R15]
						end
						if (REQ_I.op == OP_WAKE)
						begin
							pd_n_ff <= 1'b1;
							wait_ff <= CNT_W'(WAKE_WRITE_CYC > WAKE_READ_CYC ? WAKE_WRITE_CYC : WAKE_READ_CYC); // [R11]
						end
						if (REQ_I.op == OP_CLEAR)
							supply_low_seen_ff <= 1'b0; // [R1] [R15]
						if (idle_go && REQ_I.op != OP_SLEEP && REQ_I.op != OP_WAKE)
						begin
							start_ff <= 1'b1; wr_ff <= 1'b1; baddr_ff <= REQ_I.addr;
							case (REQ_I.op)
								OP_WRITE:  wdata_ff <= CMD_WRITE_SET; // [R13]
								OP_ERASE:  wdata_ff <= CMD_ERASE_SET;
								OP_CLEAR:  wdata_ff <= CMD_CLEAR_STAT;
								OP_STATUS: wdata_ff <= CMD_READ_STAT;
								default:   wdata_ff <= CMD_READ_ARRAY;
							endcase
						end
					end
				ST_CMD1:
					if (cyc_done)
					begin
						// second step of the sequence; lone setup never alters array [R9] [R13] [R14]
						start_ff <= 1'b1;
						wr_ff <= (req_ff.op == OP_WRITE || req_ff.op == OP_ERASE);
						wdata_ff <= (req_ff.op == OP_ERASE) ? CMD_ERASE_CONF : req_ff.data;
					end
				ST_CMD2, ST_POLL:
					if ((state_ff == ST_CMD2 && cyc_done) || (state_ff == ST_POLL && cyc_done && !ready_now))
					begin
						start_ff <= 1'b1; wr_ff <= 1'b0; // interpreter stays in status mode [R5]
					end
					else if (ready_now)
					begin
						STATUS_O <= cyc_rdata; // [R2]
						ERROR_O <= stat_failed(cyc_rdata);
						if (cyc_rdata[BIT_SUPPLY_LOW])
							supply_low_seen_ff <= 1'b1; // [R1]
						start_ff <= 1'b1; wr_ff <= 1'b1; wdata_ff <= CMD_READ_ARRAY; // back to array reads [R7]
					end
				ST_RDARR:
					if (cyc_done && req_ff.op == OP_READ)
					begin
						start_ff <= 1'b1; wr_ff <= 1'b0;
					end
				ST_READ:
					if (cyc_done)
					begin
						RDATA_O <= cyc_rdata;
						if (req_ff.op == OP_STATUS)
							STATUS_O <= cyc_rdata;
					end
				ST_WAKE:
					if (wait_ff != '0)
						wait_ff <= wait_ff - CNT_W'(1);
				ST_DONE:
					DONE_O <= 1'b1;
				default:
				begin
				end
			endcase
		end
	end

	// pin outputs straight from the cycle engine flops; power-down held by its own flop
	assign ADDR_O      = cyc_addr;
	assign DQ_O        = cyc_dq;
	assign DQ_OE_N_O   = cyc_dq_oe_n;
	assign CTL_O.ce_n  = cyc_cs_n;
	assign CTL_O.we_n  = cyc_we_n;
	assign CTL_O.oe_n  = cyc_oe_n;
	assign CTL_O.pd_n  = pd_n_ff;
endmodule : fcp_host

// ===== pkg/fcp_pkg.sv
// package: constants and types for the flash command/status host controller
// Functional notes
// [R1] after supply-low flag, clear status before any further write or erase
// [R2] device flags failed write and failed erase in status bits
// [R3] power-down low or supply drop aborts a running write or erase
// [R4] power-down or power-off resets upper five status bits to 10000
// [R5] interpreter keeps the last command; supply, select, sequencer do not alter it
// [R6] interpreter enters array read on power-up, wake, or core brown-out
// [R7] host issues array-read command after write or erase before array reads
// [R8] a command write needs both write strobe and chip select low
// [R9] array changes only after a complete two-step command sequence
// [R10] device ignores controls while power-down is low
// [R11] host waits wake-up delays after raising power-down before read or write
// [R12] host reissues an aborted write or erase sequence in full; code does not reissue, it refuses write or erase until cleared
// [R13] byte write is setup code then address and data write
// [R14] non-confirm after erase setup sets erase and write error flags
// [R15] error flags persist until clear-status or power-down
package fcp_pkg;
	localparam int          CLK_HZ         = 20000000;
	localparam int          WAKE_READ_NS   = 300;
	localparam int          WAKE_WRITE_NS  = 1000;
	localparam int          WAKE_READ_CYC  = (WAKE_READ_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int          WAKE_WRITE_CYC = (WAKE_WRITE_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int          STROBE_CYC     = 2;
	localparam int          CNT_W          = 8;
	localparam logic [7:0]  CMD_READ_ARRAY = 8'hff;
	localparam logic [7:0]  CMD_READ_STAT  = 8'h70;
	localparam logic [7:0]  CMD_CLEAR_STAT = 8'h50;
	localparam logic [7:0]  CMD_WRITE_SET  = 8'h40;
	localparam logic [7:0]  CMD_ERASE_SET  = 8'h20;
	localparam logic [7:0]  CMD_ERASE_CONF = 8'hd0;
	localparam int          BIT_READY      = 7;
	localparam int          BIT_ERASE_ERR  = 5;
	localparam int          BIT_WRITE_ERR  = 4;
	localparam int          BIT_SUPPLY_LOW = 3;
	localparam logic [4:0]  STAT_INIT_HI   = 5'h10;
	localparam logic [2:0]  OP_READ        = 3'h0;
	localparam logic [2:0]  OP_WRITE       = 3'h1;
	localparam logic [2:0]  OP_ERASE       = 3'h2;
	localparam logic [2:0]  OP_CLEAR       = 3'h3;
	localparam logic [2:0]  OP_STATUS      = 3'h4;
	localparam logic [2:0]  OP_SLEEP       = 3'h5;
	localparam logic [2:0]  OP_WAKE        = 3'h6;

	typedef struct packed {
		logic [2:0]  op;
		logic [19:0] addr;
		logic [7:0]  data;
	} fcp_req_t;

	typedef struct packed {
		logic        ce_n;
		logic        we_n;
		logic        oe_n;
		logic        pd_n;
	} fcp_ctl_t;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0000,
		ST_CMD1   = 4'b0001,
		ST_CMD2   = 4'b0010,
		ST_POLL   = 4'b0011,
		ST_RDARR  = 4'b0100,
		ST_READ   = 4'b0101,
		ST_SLEEP  = 4'b0110,
		ST_WAKE   = 4'b0111,
		ST_DONE   = 4'b1000,
		ST_REFUSE = 4'b1001
	} fcp_state_t;
endpackage : fcp_pkg

// ===== rtl/fcp_bus_cycle.sv
// single bus cycle engine: strobes one write or read on the flash pins
`timescale 1ns/1ps
module fcp_bus_cycle
	import fcp_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic        ce_i,
	input  wire logic        start_i,
	input  wire logic        wr_i,
	input  wire logic [19:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic [7:0]  dq_i,
	output logic             busy_o,
	output logic             done_o,
	output logic [7:0]       rdata_o,
	output logic [19:0]      addr_o,
	output logic [7:0]       dq_o,
	output logic             dq_oe_n_o,
	output logic             cs_n_o,
	output logic             we_n_o,
	output logic             oe_n_o
);
	logic [CNT_W-1:0] cnt_ff;
	logic             wr_ff;
	wire              last = (cnt_ff == CNT_W'(1));

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			cnt_ff <= '0; wr_ff <= 1'b0; busy_o <= 1'b0; done_o <= 1'b0; rdata_o <= 8'h00;
			addr_o <= 20'h00000; dq_o <= 8'h00; dq_oe_n_o <= 1'b1;
			cs_n_o <= 1'b1; we_n_o <= 1'b1; oe_n_o <= 1'b1;
		end
		else if (ce_i)
		begin
			done_o <= 1'b0;
			if (start_i && !busy_o)
			begin
				// both select and strobe low forms a command write [R8]
				busy_o <= 1'b1; wr_ff <= wr_i; cnt_ff <= CNT_W'(STROBE_CYC);
				addr_o <= addr_i; dq_o <= wdata_i; dq_oe_n_o <= !wr_i;
				cs_n_o <= 1'b0; we_n_o <= !wr_i; oe_n_o <= wr_i;
			end
			else if (busy_o)
			begin
				cnt_ff <= cnt_ff - CNT_W'(1);
				if (last)
				begin
					// data is latched on the rising strobe edge; bus released in the same cycle
					busy_o <= 1'b0; done_o <= 1'b1; cs_n_o <= 1'b1; we_n_o <= 1'b1; oe_n_o <= 1'b1;
					dq_oe_n_o <= 1'b1;
					if (!wr_ff)
						rdata_o <= dq_i;
				end
			end
		end
	end
endmodule : fcp_bus_cycle

// ===== test/fcp_host_properties.sv
// checker: pin timing and refusal done pulse of the flash host controller
`timescale 1ns/1ps
module fcp_host_checker
	import fcp_pkg::*;
(
	input wire logic        CLK_I,
	input wire logic        RSTN_I,
	input wire logic        DONE_O,
	input wire logic        REFUSED_O,
	input wire logic [19:0] ADDR_O,
	input wire logic [7:0]  DQ_O,
	input wire logic        DQ_OE_N_O,
	input wire fcp_ctl_t    CTL_O
);
	logic [7:0] wake_ff;
	logic [7:0] nxt_wake;
	// real time since wake, so a frozen clock enable cannot shorten it
	assign nxt_wake = !CTL_O.pd_n ? 8'h00 : wake_ff + {7'h00, wake_ff != 8'hff};
	always_ff @(posedge CLK_I or negedge RSTN_I)
		if (!RSTN_I)
			wake_ff <= 8'h00;
		else
			wake_ff <= nxt_wake;
	default clocking @(posedge CLK_I);
	endclocking
	default disable iff (!RSTN_I);
	property p_we_cs; !CTL_O.we_n |-> !CTL_O.ce_n; endproperty
	a_we_cs: assert property (p_we_cs) else $error("strobe without select");
	property p_dq_drv; !CTL_O.we_n |-> !DQ_OE_N_O; endproperty
	a_dq_drv: assert property (p_dq_drv) else $error("strobe without data");
	property p_hold; $fell(CTL_O.we_n) |=> !CTL_O.we_n && $stable(ADDR_O) && $stable(DQ_O); endproperty
	a_hold: assert property (p_hold) else $error("strobe too short");
	property p_wake_wr; CTL_O.pd_n && wake_ff < WAKE_WRITE_CYC |-> CTL_O.we_n; endproperty
	a_wake_wr: assert property (p_wake_wr) else $error("write too soon after wake");
	property p_wake_rd; CTL_O.pd_n && wake_ff < WAKE_READ_CYC |-> CTL_O.oe_n; endproperty
	a_wake_rd: assert property (p_wake_rd) else $error("read too soon after wake");
	property p_no_clash; !DQ_OE_N_O |-> CTL_O.oe_n; endproperty
	a_no_clash: assert property (p_no_clash) else $error("bus contention");
	property p_sleep; !CTL_O.pd_n |-> CTL_O.we_n && CTL_O.oe_n; endproperty
	a_sleep: assert property (p_sleep) else $error("strobe while asleep");
	property p_refuse; REFUSED_O |-> DONE_O ##1 !DONE_O; endproperty
	a_refuse: assert property (p_refuse) else $error("refusal not a done pulse");
endmodule : fcp_host_checker
bind fcp_host fcp_host_checker i_fcp_host_checker (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .DONE_O(DONE_O),
	.REFUSED_O(REFUSED_O), .ADDR_O(ADDR_O), .DQ_O(DQ_O), .DQ_OE_N_O(DQ_OE_N_O), .CTL_O(CTL_O));

// ===== test/fcp_flash_model.sv
// behavioural flash device: command interpreter, status and a tiny array
`timescale 1ns/1ps
module fcp_flash_model
	import fcp_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        supply_high_i,
	input  wire logic        fail_i,
	input  wire logic [5:0]  busy_len_i,
	input  wire logic [19:0] addr_i,
	input  wire logic [7:0]  dq_i,
	input  wire fcp_ctl_t    ctl_i,
	output logic [7:0]       dq_o
);
	logic [7:0] mem [16];
	logic [7:0] stat_ff = 8'h80;
	logic [7:0] cap_ff = 8'h00;
	logic [7:0] last_ff = 8'h00;
	logic [3:0] adr_ff = 4'h0;
	logic [5:0] busy_ff = 6'h00;
	logic [1:0] setup_ff = 2'h0;
	logic       wl_ff = 1'b0;
	logic       smode_ff = 1'b0;
	logic       erase_ff = 1'b0;
	logic [7:0] dq_ff = 8'hff;
	wire        rd_en = !ctl_i.ce_n && !ctl_i.oe_n && ctl_i.pd_n;
	assign dq_o = dq_ff;
	// released bus shows the inverse, never a stale byte
	// driven on the falling edge so the host never samples a byte updated in its own edge
	always @(negedge clk_i)
		dq_ff <= rd_en ? (smode_ff ? stat_ff : mem[addr_i[3:0]]) : ~last_ff;
	initial
		foreach (mem[i])
			mem[i] = 8'hff;
	always @(posedge clk_i)
	begin
		if (rd_en)
			last_ff = dq_o;
		if (!ctl_i.pd_n)
		begin
			stat_ff = 8'h80;
			smode_ff = 1'b0;
			setup_ff = 2'h0;
			busy_ff = 6'h00;
			wl_ff = 1'b0;
		end
		else
		begin
			if (busy_ff != 6'h00 && !supply_high_i)
			begin
				busy_ff = 6'h00;
				stat_ff[7] = 1'b1;
				stat_ff[3] = 1'b1;
			end
			else if (busy_ff == 6'h01)
			begin
				stat_ff[7] = 1'b1; // mode left as it was
				if (fail_i)
					stat_ff[erase_ff ? 5 : 4] = 1'b1;
				else if (erase_ff)
					foreach (mem[i])
						mem[i] = 8'hff;
				else
					mem[adr_ff] = mem[adr_ff] & cap_ff;
			end
			if (busy_ff != 6'h00)
				busy_ff = busy_ff - 6'h01;
			if (wl_ff && ctl_i.we_n && setup_ff != 2'h0)
			begin
				smode_ff = 1'b1;
				if (stat_ff[3] || !supply_high_i)
					stat_ff[3] = 1'b1;
				else if (setup_ff == 2'h2 && cap_ff != CMD_ERASE_CONF)
					stat_ff[5:4] = 2'b11;
				else
				begin
					stat_ff[7] = 1'b0;
					busy_ff = busy_len_i | 6'h01;
					erase_ff = setup_ff == 2'h2;
				end
				setup_ff = 2'h0;
			end
			else if (wl_ff && ctl_i.we_n)
				case (cap_ff)
					8'h40, 8'h10: setup_ff = 2'h1;
					CMD_ERASE_SET: setup_ff = 2'h2;
					CMD_READ_STAT: smode_ff = 1'b1;
					CMD_CLEAR_STAT: stat_ff[5:3] = 3'b000;
					CMD_READ_ARRAY: smode_ff = 1'b0;
					default: ;
				endcase
			wl_ff = !ctl_i.we_n && !ctl_i.ce_n;
			if (wl_ff)
				{adr_ff, cap_ff} = {addr_i[3:0], dq_i};
		end
	end
endmodule : fcp_flash_model

// ===== test/test_fcp_host.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ps
module test_fcp_host
	import fcp_pkg::*;
;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        ce = 1'b1;
	logic        valid = 1'b0;
	logic        supply = 1'b1;
	logic        fail = 1'b0;
	logic [5:0]  blen = 6'h03;
	logic [3:0]  a = 4'h3;
	logic [7:0]  rv = 8'h00;
	fcp_req_t    req = '0;
	logic [7:0]  dq_dev, rdata, status, dq_o;
	logic        ready, done, err, refused, oe_n;
	logic [19:0] addr;
	fcp_ctl_t    ctl;
	logic [10:0] e;
	logic [10:0] expq[$]; // refused, kind, value
	int          mismatches = 0;
	int          n_compared = 0;
	int          seed = 32'hdbeaac8b;
	fcp_host i_fcp_host (.CLK_I(clk), .RSTN_I(rstn), .CE_I(ce), .REQ_I(req), .REQ_VALID_I(valid),
		.DQ_I(dq_dev), .SUPPLY_HIGH_I(supply), .REQ_READY_O(ready), .DONE_O(done), .ERROR_O(err),
		.REFUSED_O(refused), .RDATA_O(rdata), .STATUS_O(status), .ADDR_O(addr), .DQ_O(dq_o),
		.DQ_OE_N_O(oe_n), .CTL_O(ctl));
	fcp_flash_model i_fcp_flash_model (.clk_i(clk), .supply_high_i(supply), .fail_i(fail),
		.busy_len_i(blen), .addr_i(addr), .dq_i(oe_n ? ~dq_o : dq_o), .ctl_i(ctl), .dq_o(dq_dev));
	initial
		forever
			#25 clk = ~clk;
	task automatic tally_and_finish;
		if (mismatches == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic wait_lvl(ref logic s, input logic v);
		for (int n = 0; s !== v; n++)
		begin
			if (n == 3000)
			begin
				mismatches++;
				$display("MISMATCH %0t: wait timed out", $time);
				tally_and_finish();
			end
			@(negedge clk);
		end
	endtask : wait_lvl
	task automatic do_op(input logic [2:0] op, input logic [7:0] d, input logic [10:0] x);
		expq.push_back(x);
		req = {op, 16'h0000, a, d};
		valid = 1'b1;
		wait_lvl(ready, 1'b1);
		@(negedge clk);
		wait_lvl(ready, 1'b0);
		valid = 1'b0;
		wait_lvl(done, 1'b1);
		@(negedge clk);
	endtask : do_op
	task automatic cycle_rw;
		{blen, a, rv} = 18'($random(seed));
		do_op(OP_ERASE, 8'h00, 11'h100);
		do_op(OP_WRITE, rv, 11'h100);
		do_op(OP_READ, 8'h00, {3'b010, rv});
	endtask : cycle_rw
	always @(negedge clk)
		if (done === 1'b1)
		begin
			if (expq.size() == 0)
				check(8'h01, 8'h00);
			else
			begin
				e = expq.pop_front();
				check({7'h00, refused}, {7'h00, e[10]});
				if (e[9:8] == 2'd1)
					check({7'h00, err}, e[7:0]);
				if (e[9:8] == 2'd2)
					check(rdata, e[7:0]);
				if (e[9:8] == 2'd3)
					check(status, e[7:0]);
			end
		end
	initial
	begin
		repeat (12) @(negedge clk);
		rstn = 1'b1;
		do_op(OP_WRITE, 8'h5a, 11'h400);
		do_op(OP_WAKE, 8'h00, 11'h000);
		ce = 1'b0;
		fork
			do_op(OP_READ, 8'h00, 11'h2ff);
			begin
				repeat (5) @(negedge clk);
				ce = 1'b1;
			end
		join
		repeat (4) cycle_rw();
		fail = 1'b1;
		do_op(OP_WRITE, 8'h00, 11'h101);
		do_op(OP_CLEAR, 8'h00, 11'h000);
		do_op(OP_ERASE, 8'h00, 11'h101);
		do_op(OP_CLEAR, 8'h00, 11'h000);
		fail = 1'b0;
		do_op(OP_STATUS, 8'h00, 11'h380);
		supply = 1'b0;
		do_op(OP_WRITE, 8'h00, 11'h101);
		supply = 1'b1;
		do_op(OP_WRITE, 8'h00, 11'h400);
		do_op(OP_ERASE, 8'h00, 11'h400);
		do_op(OP_CLEAR, 8'h00, 11'h000);
		blen = 6'h3f;
		fork
			do_op(OP_WRITE, 8'h00, 11'h101);
			begin
				repeat (14) @(negedge clk);
				supply = 1'b0;
			end
		join
		supply = 1'b1;
		do_op(OP_WRITE, 8'h00, 11'h400);
		do_op(OP_CLEAR, 8'h00, 11'h000);
		cycle_rw();
		fail = 1'b1;
		do_op(OP_WRITE, 8'h00, 11'h101);
		fail = 1'b0;
		do_op(OP_STATUS, 8'h00, 11'h390);
		do_op(OP_SLEEP, 8'h00, 11'h000);
		do_op(OP_STATUS, 8'h00, 11'h400);
		do_op(OP_ERASE, 8'h00, 11'h400);
		do_op(OP_WAKE, 8'h00, 11'h000);
		do_op(OP_READ, 8'h00, {3'b010, rv});
		do_op(OP_STATUS, 8'h00, 11'h380);
		tally_and_finish();
	end
endmodule : test_fcp_host
